// *** src/eq_pkg.sv ***
// Shared constants, types and lookup tables for the equalizer configuration loader
package eq_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int T_EEPROM_NS = 7500000;
   localparam int T_POR_NS = 50000000;
   // Load time is a ceiling on the fetch, so it rounds down
   localparam int EEPROM_LOAD_CYCLES = T_EEPROM_NS / CLK_PERIOD_NS;
   // Access holdoff is a least time, so it rounds up
   localparam int POR_CYCLES = (T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_CNT_W = 24;
   localparam int LOAD_CNT_W = 21;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // ----------------------------------------------------------------
   // Channels, straps and boost index
   // ----------------------------------------------------------------
   localparam int NUM_CH = 8;
   localparam int CH_PER_BANK = 4;
   localparam int NUM_BANKS = 2;
   localparam int LVL_W = 3;
   localparam logic [2:0] LVL_MAX = 3'h4;
   localparam logic [4:0] LVL_STEPS = 5'h05;
   localparam int IDX_W = 5;
   localparam logic [4:0] IDX_TOP = 5'h13;
   localparam logic [4:0] IDX_RESET = 5'h00;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [3:0] ADDR_CH_LAST = 4'h7;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h9;
   localparam logic [3:0] ADDR_IRQ_CLR = 4'ha;
   localparam logic [3:0] ADDR_STATE = 4'hb;
   localparam int CH_W = 10;
   localparam int CH_IDX_LSB = 0;
   localparam int CH_SHAPE_LSB = 5;
   localparam int CH_SHAPE_EN_BIT = 9;
   localparam logic [9:0] CH_RESET = 10'h000;
   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_READY = 2;

   // ----------------------------------------------------------------
   // EEPROM stream
   // ----------------------------------------------------------------
   localparam int EE_WORD_W = 16;
   localparam logic [3:0] EE_BIT_LAST = 4'hf;
   localparam logic [2:0] EE_WORD_LAST = 3'h7;

   typedef enum logic [1:0] {
      MODE_STRAP = 2'b00,
      MODE_PRIMARY = 2'b01,
      MODE_SECONDARY = 2'b10
   } cfg_mode_e;

   typedef enum logic [1:0] {
      FETCH_IDLE = 2'b00,
      FETCH_RUN = 2'b01,
      FETCH_DONE = 2'b10,
      FETCH_FAIL = 2'b11
   } fetch_e;

   typedef struct packed {
      logic [3:0] ctle_first_stage_code;
      logic [2:0] ctle_second_stage_code;
      logic [3:0] ctle_midband_shape;
      logic ctle_first_stage_skip;
   } eq_setting_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   localparam eq_setting_s CFG_RESET = '{4'h0, 3'h0, 4'h0, 1'b1};

   // ----------------------------------------------------------------
   // Boost index tables
   // ----------------------------------------------------------------
   localparam logic [3:0] FIRST_TBL [20] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
      4'h5, 4'h6, 4'h8, 4'ha, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
   localparam logic [2:0] SECOND_TBL [20] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
      3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
   localparam logic [3:0] SHAPE_TBL [20] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'h3,
      4'h7, 4'h7, 4'h7, 4'h7, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf};
   localparam logic [19:0] SKIP_TBL = 20'h00007;

endpackage

// *** src/boost_map.sv ***
// Boost index to equalizer stage code mapper with registered output
`timescale 1ns/10ps
module boost_map import eq_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] idx,
   input wire logic shape_en,
   input wire logic [3:0] shape,
   output eq_setting_s cfg_q
);

   // ----------------------------------------------------------------
   // Lookup
   // ----------------------------------------------------------------
   // Out-of-range register values saturate at the top step
   wire [4:0] idx_c = (idx > IDX_TOP) ? IDX_TOP : idx;
   wire eq_setting_s cfg_d = '{FIRST_TBL[idx_c], SECOND_TBL[idx_c],
      shape_en ? shape : SHAPE_TBL[idx_c], SKIP_TBL[idx_c]};

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_q <= CFG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_top_step_codes: assert property (@(posedge clk) disable iff (rst)
      (idx == IDX_TOP && !shape_en) |=> (cfg_q.ctle_first_stage_code == 4'hf
      && cfg_q.ctle_second_stage_code == 3'h7 && cfg_q.ctle_midband_shape == 4'hf))
      else $error("top boost step mapped wrongly");

   a_skip_low_only: assert property (@(posedge clk) disable iff (rst)
      ##1 (cfg_q.ctle_first_stage_skip == ($past(idx_c) < 5'h03)))
      else $error("first stage skip flag wrong for index");

endmodule

// *** src/redriver_eq_config_loader.sv ***
// Equalizer configuration loader: strap, EEPROM fetch and register control of eight channels
//
// Contract
// - Strap mode takes full configuration from strap levels, no bus access needed.
// - Primary mode fetches from EEPROM; success drives load-complete output low.
// - Register accesses are accepted before, during and after the EEPROM fetch.
// - Midband shape adjustable only under register control; strap uses fixed table.
// - Bank 0 straps set channels 0-3, bank 1 straps channels 4-7.
// - Register control holds an independent boost setting per channel.
// - Strap pairs decode to index 0..24, saturated at 19; index 19 gives codes 15, 7, 15.
// - Setting is 4-bit first, 3-bit second, 4-bit shape, skip for three lowest.
// - Register accesses take effect only about 50 ms after power-on.
// - EEPROM load completes within 7.5 ms of fetch enable.
// - Boost straps are sampled once at power-up, later changes ignored.
`timescale 1ns/10ps
module redriver_eq_config_loader import eq_pkg::*; #(
   parameter int POR_WAIT = POR_CYCLES,
   parameter int LOAD_WAIT = EEPROM_LOAD_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] boost_select_hi_bank0,
   input wire logic [2:0] boost_select_lo_bank0,
   input wire logic [2:0] boost_select_hi_bank1,
   input wire logic [2:0] boost_select_lo_bank1,
   input wire logic [1:0] cfg_mode_pin,
   input wire logic fetch_en_n,
   input wire logic ee_clk,
   input wire logic ee_data,
   input wire logic ee_frame,
   input wire reg_req_s bus,
   output logic [15:0] rdata_q,
   output logic ee_req_q,
   output logic all_done_n_q,
   output logic irq_q,
   output eq_setting_s ch_cfg_q [NUM_CH]
);

   localparam int PIN_W = 18;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pin_s1_q;
   logic [PIN_W-1:0] pin_s2_q;
   logic ee_clk_prev_q;
   logic ee_frame_prev_q;

   wire [PIN_W-1:0] pins = {boost_select_hi_bank0, boost_select_lo_bank0, boost_select_hi_bank1,
      boost_select_lo_bank1, cfg_mode_pin, fetch_en_n, ee_clk, ee_data, ee_frame};

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         ee_clk_prev_q <= 1'b0;
         ee_frame_prev_q <= 1'b0;
      end else begin
         pin_s1_q <= pins;
         pin_s2_q <= pin_s1_q;
         ee_clk_prev_q <= pin_s2_q[2];
         ee_frame_prev_q <= pin_s2_q[0];
      end
   end

   wire [2:0] hi0_s = pin_s2_q[17:15];
   wire [2:0] lo0_s = pin_s2_q[14:12];
   wire [2:0] hi1_s = pin_s2_q[11:9];
   wire [2:0] lo1_s = pin_s2_q[8:6];
   wire cfg_mode_e mode_s = cfg_mode_e'(pin_s2_q[5:4]);
   wire fetch_en_n_s = pin_s2_q[3];
   wire ee_clk_s = pin_s2_q[2];
   wire ee_data_s = pin_s2_q[1];
   wire ee_frame_s = pin_s2_q[0];
   wire ee_rise = ee_clk_s && !ee_clk_prev_q;
   wire ee_frame_fall = ee_frame_prev_q && !ee_frame_s;
   wire strap_mode = (mode_s == MODE_STRAP);
   wire primary_mode = (mode_s == MODE_PRIMARY);

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   // Levels above the fifth step are read as the top (floating) level
   wire [2:0] hi0_c = (hi0_s > LVL_MAX) ? LVL_MAX : hi0_s;
   wire [2:0] lo0_c = (lo0_s > LVL_MAX) ? LVL_MAX : lo0_s;
   wire [2:0] hi1_c = (hi1_s > LVL_MAX) ? LVL_MAX : hi1_s;
   wire [2:0] lo1_c = (lo1_s > LVL_MAX) ? LVL_MAX : lo1_s;
   wire [4:0] bank0_idx_d = 5'({2'b00, hi0_c}) * LVL_STEPS + 5'({2'b00, lo0_c});
   wire [4:0] bank1_idx_d = 5'({2'b00, hi1_c}) * LVL_STEPS + 5'({2'b00, lo1_c});

   logic [1:0] strap_cnt_q;
   logic strap_valid_q;
   logic [4:0] bank_idx_q [NUM_BANKS];

   // Caught once after the synchronisers fill; never re-read
   always_ff @(posedge clk) begin
      if (rst) begin
         strap_cnt_q <= 2'h0;
         strap_valid_q <= 1'b0;
         bank_idx_q[0] <= IDX_RESET;
         bank_idx_q[1] <= IDX_RESET;
      end else if (!strap_valid_q) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == STRAP_SETTLE) begin
            strap_valid_q <= 1'b1;
            bank_idx_q[0] <= bank0_idx_d;
            bank_idx_q[1] <= bank1_idx_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // Power-on access holdoff
   // ----------------------------------------------------------------
   logic [POR_CNT_W-1:0] por_cnt_q;
   logic ready_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         por_cnt_q <= '0;
         ready_q <= 1'b0;
      end else if (!ready_q) begin
         por_cnt_q <= por_cnt_q + 1'b1;
         ready_q <= (por_cnt_q == POR_CNT_W'(POR_WAIT - 1));
      end
   end

   // ----------------------------------------------------------------
   // EEPROM fetch
   // ----------------------------------------------------------------
   fetch_e fetch_q;
   fetch_e fetch_d;
   logic [LOAD_CNT_W-1:0] load_cnt_q;
   logic [3:0] bit_cnt_q;
   logic [2:0] word_cnt_q;
   logic [EE_WORD_W-2:0] shift_q;

   wire load_expired = (load_cnt_q == LOAD_CNT_W'(LOAD_WAIT - 1));
   wire bit_take = (fetch_q == FETCH_RUN) && ee_frame_s && ee_rise;
   wire word_end = bit_take && (bit_cnt_q == EE_BIT_LAST);
   wire last_word = word_end && (word_cnt_q == EE_WORD_LAST);
   wire [EE_WORD_W-1:0] ee_word = {shift_q, ee_data_s};

   always_comb begin
      fetch_d = fetch_q;
      case (fetch_q)
         FETCH_IDLE: begin
            if (primary_mode && !fetch_en_n_s) begin
               fetch_d = FETCH_RUN;
            end
         end
         FETCH_RUN: begin
            if (last_word) begin
               fetch_d = FETCH_DONE;
            end else if (load_expired || ee_frame_fall) begin
               fetch_d = FETCH_FAIL;
            end
         end
         FETCH_DONE, FETCH_FAIL: begin
            if (fetch_en_n_s) begin
               fetch_d = FETCH_IDLE;
            end
         end
         default: fetch_d = FETCH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fetch_q <= FETCH_IDLE;
         load_cnt_q <= '0;
         bit_cnt_q <= 4'h0;
         word_cnt_q <= 3'h0;
         shift_q <= '0;
      end else begin
         fetch_q <= fetch_d;
         load_cnt_q <= (fetch_q == FETCH_RUN) ? load_cnt_q + 1'b1 : '0;
         if (fetch_q != FETCH_RUN) begin
            bit_cnt_q <= 4'h0;
            word_cnt_q <= 3'h0;
         end else if (bit_take) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shift_q <= ee_word[EE_WORD_W-2:0];
            if (word_end) begin
               word_cnt_q <= word_cnt_q + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ee_req_q <= 1'b0;
         all_done_n_q <= 1'b1;
      end else begin
         ee_req_q <= (fetch_d == FETCH_RUN);
         all_done_n_q <= (fetch_q != FETCH_DONE);
      end
   end

   // ----------------------------------------------------------------
   // Channel registers
   // ----------------------------------------------------------------
   // Writes before the holdoff ends are dropped; a controller write racing the fetch
   // word to the same channel wins over it in that cycle
   wire bus_wr = bus.wr && ready_q;
   wire bus_rd = bus.rd && ready_q;
   wire bus_ch_hit = (bus.addr <= ADDR_CH_LAST);
   logic [CH_W-1:0] ch_q [NUM_CH];
   logic [4:0] sel_idx [NUM_CH];
   logic sel_shape_en [NUM_CH];

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      wire ee_hit = word_end && (word_cnt_q == 3'(c));
      wire bus_hit = bus_wr && bus_ch_hit && (bus.addr == 4'(c));

      // Controller write lands after the fetch word in the same cycle
      always_ff @(posedge clk) begin
         if (rst) begin
            ch_q[c] <= CH_RESET;
         end else if (bus_hit) begin
            ch_q[c] <= bus.wdata[CH_W-1:0];
         end else if (ee_hit) begin
            ch_q[c] <= ee_word[CH_W-1:0];
         end
      end

      // Straps drive per bank, with the fixed shape table
      assign sel_idx[c] = strap_mode ? bank_idx_q[c / CH_PER_BANK] : ch_q[c][CH_IDX_LSB +: IDX_W];
      assign sel_shape_en[c] = !strap_mode && ch_q[c][CH_SHAPE_EN_BIT];

      boost_map u_map (
         .clk(clk),
         .rst(rst),
         .idx(sel_idx[c]),
         .shape_en(sel_shape_en[c]),
         .shape(ch_q[c][CH_SHAPE_LSB +: 4]),
         .cfg_q(ch_cfg_q[c])
      );
   end

   // ----------------------------------------------------------------
   // Interrupts and readback
   // ----------------------------------------------------------------
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_en_q;
   logic ready_prev_q;

   wire [IRQ_W-1:0] irq_set = {ready_q && !ready_prev_q,
      fetch_d == FETCH_FAIL && fetch_q != FETCH_FAIL,
      fetch_d == FETCH_DONE && fetch_q != FETCH_DONE};
   wire [IRQ_W-1:0] irq_clr = (bus_wr && bus.addr == ADDR_IRQ_CLR) ? bus.wdata[IRQ_W-1:0] : '0;
   wire [3:0] ch_sel = bus_ch_hit ? bus.addr : 4'h0;
   wire [15:0] read_word = bus_ch_hit ? 16'(ch_q[ch_sel[2:0]])
      : (bus.addr == ADDR_IRQ_STAT) ? 16'(irq_stat_q)
      : (bus.addr == ADDR_IRQ_EN) ? 16'(irq_en_q)
      : (bus.addr == ADDR_STATE) ? 16'({mode_s, fetch_q, strap_valid_q, ready_q})
      : 16'h0000;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat_q <= '0;
         irq_en_q <= '0;
         ready_prev_q <= 1'b0;
         irq_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         // A fresh event beats a clear in the same cycle
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         if (bus_wr && bus.addr == ADDR_IRQ_EN) begin
            irq_en_q <= bus.wdata[IRQ_W-1:0];
         end
         ready_prev_q <= ready_q;
         irq_q <= |(irq_stat_q & irq_en_q);
         rdata_q <= bus_rd ? read_word : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_fetch_done;
      fetch_q == FETCH_DONE;
   endsequence

   sequence s_fetch_fail;
      fetch_q == FETCH_FAIL;
   endsequence

   a_done_pin_low: assert property (@(posedge clk) disable iff (rst)
      s_fetch_done |=> !all_done_n_q)
      else $error("load complete not low after successful fetch");

   a_fail_pin_high: assert property (@(posedge clk) disable iff (rst)
      s_fetch_fail |=> all_done_n_q)
      else $error("load complete low after failed fetch");

   a_load_time_bound: assert property (@(posedge clk) disable iff (rst)
      (fetch_q == FETCH_RUN) |-> (load_cnt_q < LOAD_CNT_W'(LOAD_WAIT)))
      else $error("EEPROM load ran past its time");

   a_strap_frozen: assert property (@(posedge clk) disable iff (rst)
      (strap_valid_q && $past(strap_valid_q)) |-> ($stable(bank_idx_q[0]) && $stable(bank_idx_q[1])))
      else $error("strap index changed after capture");

   a_strap_banks: assert property (@(posedge clk) disable iff (rst)
      strap_mode |-> (sel_idx[0] == bank_idx_q[0] && sel_idx[3] == bank_idx_q[0]
      && sel_idx[4] == bank_idx_q[1] && sel_idx[7] == bank_idx_q[1]))
      else $error("strap bank routed to wrong channels");

   // Mapper output lags the selected index by one edge; out-of-range straps saturate elsewhere
   a_strap_shape_fixed: assert property (@(posedge clk) disable iff (rst)
      (strap_mode && bank_idx_q[0] <= IDX_TOP)
      |=> (ch_cfg_q[0].ctle_midband_shape == SHAPE_TBL[$past(bank_idx_q[0])]))
      else $error("strap mode shape not from fixed table");

   a_channel_write: assert property (@(posedge clk) disable iff (rst)
      (bus_wr && bus.addr == 4'h5) |=> (ch_q[5] == $past(bus.wdata[CH_W-1:0])
      && ($stable(ch_q[4]) || $past(word_end))))
      else $error("channel write not stored independently");

   a_holdoff_writes: assert property (@(posedge clk) disable iff (rst)
      (!ready_q && bus.wr) |=> ((($stable(ch_q[0]) && $stable(ch_q[1])) || $past(word_end))
      && $stable(irq_en_q)))
      else $error("write took effect during power-on holdoff");

endmodule

// *** verif/ee_source.sv ***
// Far-end model of the serial configuration stream that feeds the fetch
`timescale 1ns/10ps
module ee_source (
   input wire logic req,
   output logic ee_clk,
   output logic ee_data,
   output logic ee_frame
);
   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   // Stream clock stands still outside frames
   initial begin
      ee_clk = 1'b0;
      ee_data = 1'b0;
      ee_frame = 1'b0;
   end

   // ----------------------------------------------------------------
   // Frame generator
   // ----------------------------------------------------------------
   // Words go MSB first; a short bit count drops the frame early
   task automatic send(input logic [15:0] w [8], input int nbits);
      int i;
      wait (req === 1'b1);
      // Odd offset keeps every stream change away from the sampling edge
      #26 ee_frame = 1'b1;
      for (i = 0; i < nbits; i++) begin
         ee_data = w[i / 16][15 - (i % 16)];
         #40 ee_clk = 1'b1;
         #40 ee_clk = 1'b0;
      end
      #40 ee_frame = 1'b0;
      // Data is not held once the frame is over
      ee_data = ~ee_data;
   endtask
endmodule

// *** verif/tb_redriver_eq_config_loader.sv ***
// Self-checking testbench of the equalizer configuration loader
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_redriver_eq_config_loader import eq_pkg::*; ;
   logic clk, rst, fetch_en_n, rd_d;
   logic [2:0] hi0, lo0, hi1, lo1;
   logic [1:0] cfg_mode_pin;
   reg_req_s bus;
   logic [15:0] rdata_q, e;
   logic ee_req_q, all_done_n_q, irq_q, ee_clk, ee_data, ee_frame;
   eq_setting_s ch_cfg_q [NUM_CH];
   int err_count = 0, num_checks = 0, cyc = 0;
   logic [15:0] exp_q [$];
   logic [15:0] words [8];
   logic [15:0] chw [8];

   // ----------------------------------------------------------------
   // Design, far end and clock
   // ----------------------------------------------------------------
   // Short holdoff and load limit keep the run brief
   redriver_eq_config_loader #(.POR_WAIT(50), .LOAD_WAIT(20000)) dut_u (
      .clk(clk), .rst(rst), .boost_select_hi_bank0(hi0), .boost_select_lo_bank0(lo0),
      .boost_select_hi_bank1(hi1), .boost_select_lo_bank1(lo1), .cfg_mode_pin(cfg_mode_pin),
      .fetch_en_n(fetch_en_n), .ee_clk(ee_clk), .ee_data(ee_data), .ee_frame(ee_frame), .bus(bus),
      .rdata_q(rdata_q), .ee_req_q(ee_req_q), .all_done_n_q(all_done_n_q), .irq_q(irq_q),
      .ch_cfg_q(ch_cfg_q));
   ee_source u_ee (.req(ee_req_q), .ee_clk(ee_clk), .ee_data(ee_data), .ee_frame(ee_frame));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic eq_setting_s exp_cfg(input logic [9:0] r);
      logic [4:0] i;
      i = r[4:0];
      return '{FIRST_TBL[i], SECOND_TBL[i], r[9] ? r[8:5] : SHAPE_TBL[i], SKIP_TBL[i]};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] x);
      exp_q.push_back(x);
      @(posedge clk);
      bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      rd_d <= bus.rd;
      if (rd_d === 1'b1) begin
         e = exp_q.pop_front();
         `CHK("rdata_q", e, rdata_q)
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_count++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int i, c;
      void'($urandom(32'h98ea451a));
      rst = 1'b1;
      bus = '0;
      hi0 = 3'h3;
      lo0 = 3'h4;
      hi1 = 3'h0;
      lo1 = 3'h0;
      cfg_mode_pin = 2'b00;
      fetch_en_n = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wr(4'h1, 16'h0013);
      repeat (10) @(posedge clk);
      for (c = 0; c < 8; c++) begin
         `CHK("strap_cfg", (c < 4) ? 12'hffe : 12'h001, ch_cfg_q[c])
      end
      hi0 <= 3'h0;
      lo0 <= 3'h0;
      hi1 <= 3'h4;
      lo1 <= 3'h4;
      repeat (50) @(posedge clk);
      `CHK("strap_hold0", 12'hffe, ch_cfg_q[0])
      `CHK("strap_hold4", 12'h001, ch_cfg_q[4])
      rd(4'h1, 16'h0000);
      wr(4'h0, 16'h02a2);
      repeat (4) @(posedge clk);
      `CHK("strap_shape", 12'hffe, ch_cfg_q[0])
      cfg_mode_pin <= 2'b10;
      repeat (8) @(posedge clk);
      `CHK("reg_shape", exp_cfg(10'h2a2), ch_cfg_q[0])
      for (c = 1; c < 8; c++) begin
         chw[c] = {6'h00, 1'($urandom), 4'($urandom), 5'($urandom % 20)};
         wr(4'(c), chw[c]);
      end
      repeat (4) @(posedge clk);
      for (c = 1; c < 8; c++) begin
         `CHK("reg_cfg", exp_cfg(chw[c][9:0]), ch_cfg_q[c])
         rd(4'(c), chw[c]);
      end
      rd(4'hc, 16'h0000);
      // ----------------------------------------------------------------
      // Fetch with a controller access in mid-stream
      // ----------------------------------------------------------------
      wr(ADDR_IRQ_EN, 16'h0001);
      for (c = 0; c < 8; c++) begin
         words[c] = {6'($urandom), 5'h00, 5'($urandom % 20)};
      end
      cfg_mode_pin <= 2'b01;
      fetch_en_n <= 1'b0;
      for (i = 0; i < 20 && ee_req_q !== 1'b1; i++) @(posedge clk);
      `CHK("ee_req", 1'b1, ee_req_q)
      fork
         u_ee.send(words, 128);
         begin
            repeat (20) @(posedge clk);
            // Bench and fetch share the register port without collision
            wr(4'h7, 16'h0013);
            rd(ADDR_STATE, 16'h0017);
         end
      join
      for (i = 0; i < 100 && all_done_n_q !== 1'b0; i++) @(posedge clk);
      `CHK("all_done_n", 1'b0, all_done_n_q)
      repeat (2) @(posedge clk);
      `CHK("irq_done", 1'b1, irq_q)
      for (c = 0; c < 8; c++) begin
         `CHK("fetch_cfg", exp_cfg(words[c][9:0]), ch_cfg_q[c])
      end
      wr(4'h6, 16'h0013);
      repeat (3) @(posedge clk);
      `CHK("late_write", 12'hffe, ch_cfg_q[6])
      wr(ADDR_IRQ_CLR, 16'h0001);
      repeat (3) @(posedge clk);
      `CHK("irq_clear", 1'b0, irq_q)
      // ----------------------------------------------------------------
      // Truncated fetch
      // ----------------------------------------------------------------
      fetch_en_n <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK("done_idle", 1'b1, all_done_n_q)
      fetch_en_n <= 1'b0;
      for (i = 0; i < 20 && ee_req_q !== 1'b1; i++) @(posedge clk);
      u_ee.send(words, 20);
      repeat (10) @(posedge clk);
      `CHK("fail_done_n", 1'b1, all_done_n_q)
      `CHK("fail_masked", 1'b0, irq_q)
      `CHK("ee_req_idle", 1'b0, ee_req_q)
      rd(ADDR_IRQ_STAT, 16'h0006);
      repeat (4) @(posedge clk);
      stop_test();
   end
endmodule
